/* File: sim/host_model.sv */
// Purpose: host side of the card bus, paces and collects the status stream
// Assumes: one status frame per start pulse, bits arrive MSB first
// Notes: bus clock stands low outside frames, phase offset from ref clock
`timescale 1ns/10ps
module host_model
(
    // reference clock
    input  wire logic         ref_clk_i,
    // frame control
    input  wire logic         start_i,
    output logic              done_o,
    // card bus
    output logic              bus_clk_o,
    input  wire logic         stat_bit_i,
    input  wire logic         stat_valid_i,
    input  wire logic         stat_last_i,
    output logic [511:0]      frame_o
);
    logic         active_r = 1'b0;
    logic         done_r   = 1'b0;
    logic [511:0] frame_r  = '0;

    assign done_o  = done_r;
    assign frame_o = frame_r;

    // 320 ns bus clock, well under the high-speed ceiling; one card only
    initial
    begin
        bus_clk_o = 1'b0;
        #7;
        forever
        begin
            #160;
            bus_clk_o = active_r ? ~bus_clk_o : 1'b0;
        end
    end

    // collect bits; stop the clock once the last bit is in
    always @(posedge ref_clk_i)
    begin
        if (start_i)
        begin
            active_r <= 1'b1;
            done_r   <= 1'b0;
        end
        else if (stat_valid_i)
        begin
            frame_r <= {frame_r[510:0], stat_bit_i};
            if (stat_last_i)
            begin
                active_r <= 1'b0;
                done_r   <= 1'b1;
            end
        end
    end
endmodule

/* File: sim/tb_switch_function_status.sv */
// Purpose: self-checking bench for the switch-function status block
// Assumes: host model paces the stream, expectations built by predict
// Notes: support-bit field is left unchecked, it lies outside this block
`timescale 1ns/10ps
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb_switch_function_status;
    logic         ref_clk, reset_n, bus_clk, cmd_valid, switch_mode, cmd_ready;
    logic         vendor_busy, secure_busy, commerce_busy, ver1;
    logic         stat_bit, stat_valid, stat_last, high_speed, host_start, host_done;
    logic [23:0]  cmd_arg, selection, exp_sel;
    logic [5:0]   grp_sup;
    logic [95:0]  sup_bits;
    logic [15:0]  acc_busy;
    logic [511:0] status_word, frame;
    logic [399:0] exp_w;
    int           error_cnt = 0;
    int           samples_checked = 0;
    int           cycles = 0;
    int           seed = 41330;

    switch_function_status i_switch_function_status (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .bus_clk_i(bus_clk), .cmd_valid_i(cmd_valid), .switch_mode_i(switch_mode),
        .cmd_arg_i(cmd_arg), .cmd_ready_o(cmd_ready), .group_supported_i(grp_sup),
        .support_bits_i(sup_bits), .access_busy_i(acc_busy),
        .vendor_specific_busy_bit_i(vendor_busy), .secure_application_busy_bit_i(secure_busy),
        .mobile_commerce_busy_bit_i(commerce_busy), .version_one_i(ver1),
        .stat_bit_o(stat_bit), .stat_valid_o(stat_valid), .stat_last_o(stat_last),
        .selection_o(selection), .high_speed_o(high_speed), .status_word_o(status_word));

    host_model i_host_model (.ref_clk_i(ref_clk), .start_i(host_start), .done_o(host_done),
        .bus_clk_o(bus_clk), .stat_bit_i(stat_bit), .stat_valid_i(stat_valid),
        .stat_last_i(stat_last), .frame_o(frame));

    // 25 MHz reference clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // expected low 400 bits of the status image and the next selection
    function automatic void predict(input logic mode, input logic [23:0] arg,
                                    output logic [399:0] w, inout logic [23:0] sel);
        logic [15:0] m, b, b2;
        logic [3:0]  a, c, st;
        logic        err;
        logic [23:0] nsel;
        err  = 1'b0;
        nsel = sel;
        w    = '0;
        b2   = {1'b0, vendor_busy, 9'h000, secure_busy, 2'h0, commerce_busy, 1'b0};
        for (int g = 0; g < 6; g++)
        begin
            a = arg[4*g+:4];
            c = sel[4*g+:4];
            m = sup_bits[16*g+:16] | 16'h8001;
            b = (g == 0) ? acc_busy : (g == 1) ? b2 : 16'h0000;
            if (!grp_sup[g])
                st = (a == 4'h0 || a == 4'hF) ? 4'h0 : 4'hF;
            else if (a == 4'h0)
                st = 4'h0;
            else if (a == 4'hF || (m[a] && b[a]))
                st = c;
            else
                st = m[a] ? a : 4'hF;
            err = err | (st == 4'hF);
            nsel[4*g+:4] = grp_sup[g] ? st : c;
            w[376+4*g+:4] = st;
        end
        w[375:368] = ver1 ? 8'h01 : 8'h00;
        if (ver1)
            w[303:272] = {b2, acc_busy};
        if (mode && !err)
            sel = nsel;
    endfunction

    // one command, whole frame collected, then all comparisons
    task automatic run_cmd(input logic mode, input logic [23:0] arg);
        predict(mode, arg, exp_w, exp_sel);
        @(posedge ref_clk);
        #1;
        cmd_valid   = 1'b1;
        switch_mode = mode;
        cmd_arg     = arg;
        host_start  = 1'b1;
        @(posedge ref_clk);
        #1;
        cmd_valid  = 1'b0;
        host_start = 1'b0;
        for (int n = 0; n < 6000 && host_done !== 1'b1; n++)
            @(posedge ref_clk);
        // a frame that never ends counts against the run
        if (host_done !== 1'b1)
            error_cnt++;
        @(posedge ref_clk);
        #1;
        `CHECK(status_word[399:376], exp_w[399:376])
        `CHECK(frame[399:376], exp_w[399:376])
        `CHECK(status_word[375:368], exp_w[375:368])
        `CHECK(status_word[367:272], exp_w[367:272])
        `CHECK(frame[375:272], exp_w[375:272])
        `CHECK(frame[271:0], exp_w[271:0])
        `CHECK(selection, exp_sel)
        `CHECK(high_speed, exp_sel[3:0] == 4'h1)
    endtask

    task automatic give_verdict();
        $display("error_cnt=%0d samples_checked=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // hang guard, about 19 frames of 4096 cycles are expected
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    initial
    begin
        logic [31:0] r;
        logic [23:0] arg;
        {reset_n, cmd_valid, switch_mode, host_start, cmd_arg, exp_sel} = '0;
        {vendor_busy, secure_busy, commerce_busy, acc_busy} = '0;
        ver1     = 1'b1;
        grp_sup  = 6'h03;
        sup_bits = {64'h0, 16'hC013, 16'h8003};
        repeat (6) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        @(posedge ref_clk);
        #1;
        `CHECK(selection, 24'h000000)
        `CHECK(high_speed, 1'b0)
        `CHECK(cmd_ready, 1'b1)
        run_cmd(1'b0, 24'hFFFFF1);
        run_cmd(1'b0, 24'hFFFFF2);
        run_cmd(1'b1, 24'hFFFFF1);
        acc_busy = 16'h0002;
        run_cmd(1'b1, 24'hFFFFF0);
        run_cmd(1'b1, 24'hFFFFF1);
        run_cmd(1'b0, 24'hFFFFF1);
        {vendor_busy, secure_busy, commerce_busy} = 3'h7;
        run_cmd(1'b0, 24'hFFFF1F);
        acc_busy = 16'h0000;
        run_cmd(1'b1, 24'hFFFFF1);
        run_cmd(1'b1, 24'hFFF2F0);
        run_cmd(1'b0, 24'hFFFE0F);
        ver1 = 1'b0;
        run_cmd(1'b0, 24'hFFFFFF);
        for (int k = 0; k < 8; k++)
        begin
            grp_sup  = 6'($random(seed));
            sup_bits = {$random(seed), $random(seed), $random(seed)};
            acc_busy = 16'($random(seed));
            {vendor_busy, secure_busy, commerce_busy, ver1} = 4'($random(seed));
            r   = $random(seed);
            arg = r[23:0];
            if (r[31])
                arg[23:4] = 20'hFFFFF;
            run_cmd(r[30], arg);
        end
        give_verdict();
    end
endmodule

/* File: src/group_decide.sv */
// Purpose: per-group status code and switch decision
// Assumes: support mask has bits 0 and 15 set by the caller
// Notes: purely combinational
`timescale 1ns/10ps
`include "switch_function_regs.svh"
module group_decide
(
    // group configuration
    input  wire logic        group_supported_i,
    input  wire logic [15:0] support_mask_i,
    input  wire logic [15:0] busy_mask_i,
    input  wire logic [3:0]  current_i,
    // request
    input  wire logic        switch_mode_i,
    input  wire logic [3:0]  arg_i,
    // result
    output logic      [3:0]  status_o,
    output logic             error_o,
    output logic             change_o
);
    wire is_default = (arg_i == `SF_CODE_DEFAULT);
    wire is_keep    = (arg_i == `SF_CODE_KEEP);
    wire supp       = support_mask_i[arg_i];
    wire busy       = busy_mask_i[arg_i];

    // code table; mode only matters for change_o
    always_comb
    begin
        error_o  = 1'b0;
        change_o = 1'b0;
        if (!group_supported_i)
        begin
            status_o = (is_default || is_keep) ? `SF_CODE_DEFAULT : `SF_CODE_KEEP;
            error_o  = !(is_default || is_keep);
        end
        else if (is_keep)
            status_o = current_i;
        else if (is_default)
        begin
            status_o = `SF_CODE_DEFAULT;
            change_o = switch_mode_i;
        end
        else if (!supp)
        begin
            status_o = `SF_CODE_KEEP;
            error_o  = 1'b1;
        end
        else if (busy)
            status_o = current_i;
        else
        begin
            status_o = arg_i;
            change_o = switch_mode_i;
        end
    end
endmodule

/* File: src/link_clock_edge.sv */
// Purpose: synchronise the host bus clock and find its rising edge
// Assumes: bus clock slower than half the reference clock
// Notes: first flop feeds only the second
`timescale 1ns/10ps
module link_clock_edge
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    // link clock pin
    input  wire logic bus_clk_i,
    // rising edge pulse
    output logic      rise_o
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // two-flop synchroniser plus edge history
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end
        else
        begin
            meta_r <= bus_clk_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise_o = sync_r & ~last_r;
endmodule

/* File: src/switch_function_pkg.sv */
// Purpose: types for the switch-function status block
// Assumes: nothing beyond the constants header
// Notes: states of the status shifter
package switch_function_pkg;
    typedef enum logic [1:0] {st_idle, st_build, st_shift} state_type;
    typedef logic [3:0] code_type;
endpackage

/* File: src/switch_function_regs.svh */
// Purpose: constants for the switch-function status block
// Assumes: 512-bit status structure, six function groups of four bits
// Notes: shared by the group decoder and the status block design files
// Summary of operation
// - busy bit reads 0 when function ready, 1 when busy
// - sixteen busy bits per group 1..6 at 287:272 up to 367:352, both modes
// - mode 1 changes only ready functions; busy ones keep selection
// - failed mode 1 reporting current function means function is busy
// - group 2 busy: bit 302 vendor, 292 secure app, 289 commerce, rest 0
// - version field reads only 00h or 01h
// - busy bits valid only with version 01h; 00h defines 511:376 only
// - 4-bit code per group from argument 23:0, status in 399:376
// - mode 0 argument 0 gives status 0 on supported group
// - mode 0 ready supported function returns argument code
// - mode 0 busy supported function returns current selection
// - mode 0 unsupported function returns Fh
// - argument Fh keeps selection and reports current function
// - mode 1 argument 0 switches group to default, status 0
// - mode 1 ready supported function gets selected and reported
// - mode 1 busy supported function cancelled, current reported
// - mode 1 any Fh group cancels switch in all groups
// - unsupported group: 0 for argument 0 or Fh, Fh for 1h..Eh
// - power-up in default speed; high speed optional via access group
// - status field: mode 0 switchable, mode 1 result, Fh is error
`ifndef SWITCH_FUNCTION_REGS_SVH
`define SWITCH_FUNCTION_REGS_SVH
`define SF_GROUPS        6
`define SF_STATUS_BITS   512
`define SF_SEL_LSB       376
`define SF_VER_LSB       368
`define SF_BUSY_LSB      272
`define SF_BUSY_G2_LSB   288
`define SF_CODE_DEFAULT  4'h0
`define SF_CODE_KEEP     4'hF
`define SF_VER_0         8'h00
`define SF_VER_1         8'h01
`define SF_FN_HIGH_SPEED 4'h1
`define SF_G2_VS_BIT     14
`define SF_G2_SA_BIT     4
`define SF_G2_MC_BIT     1
`define SF_G2_MASK       16'h4012
`define SF_SHIFT_MSB     511
`define SF_COUNT_TOP     9'h1FF
`endif

/* File: src/switch_function_status.sv */
// Purpose: answer the switch-function command with a 512-bit status block
// Assumes: command decoding done upstream; data pin sampled on bus clock
// Notes: status shifted MSB first, one bit per rising bus clock edge
`timescale 1ns/10ps
`include "switch_function_regs.svh"
module switch_function_status
(
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         reset_n_i,
    // host bus clock
    input  wire logic         bus_clk_i,
    // command request
    input  wire logic         cmd_valid_i,
    input  wire logic         switch_mode_i,
    input  wire logic [23:0]  cmd_arg_i,
    output logic              cmd_ready_o,
    // configuration
    input  wire logic [5:0]   group_supported_i,
    input  wire logic [95:0]  support_bits_i,
    input  wire logic [15:0]  access_busy_i,
    input  wire logic         vendor_specific_busy_bit_i,
    input  wire logic         secure_application_busy_bit_i,
    input  wire logic         mobile_commerce_busy_bit_i,
    input  wire logic         version_one_i,
    // status stream
    output logic              stat_bit_o,
    output logic              stat_valid_o,
    output logic              stat_last_o,
    // current selections
    output logic [23:0]       selection_o,
    output logic              high_speed_o,
    output logic [511:0]      status_word_o
);
    switch_function_pkg::state_type state_r;
    switch_function_pkg::state_type state_nxt;
    logic [23:0]  sel_r;
    logic [511:0] shift_r;
    logic [511:0] word_r;
    logic [8:0]   count_r;
    logic         mode_r;
    logic [23:0]  arg_r;
    logic         rise;
    logic [23:0]  codes;
    logic [5:0]   errs;
    logic [5:0]   chg;
    logic [63:0]  busy_low;
    logic [95:0]  busy_all;
    logic [95:0]  supp_all;

    link_clock_edge u_edge
    (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .bus_clk_i (bus_clk_i),
        .rise_o    (rise)
    );

    // group 2 busy field holds only the three command-system bits
    wire [15:0] g2_busy = (16'h0000
        | ({15'h0000, vendor_specific_busy_bit_i} << `SF_G2_VS_BIT)
        | ({15'h0000, secure_application_busy_bit_i} << `SF_G2_SA_BIT)
        | ({15'h0000, mobile_commerce_busy_bit_i} << `SF_G2_MC_BIT))
        & `SF_G2_MASK;
    // busy known for groups 1,2 only; groups 3..6 report none
    assign busy_low = {16'h0000, 16'h0000, g2_busy, access_busy_i};
    assign busy_all = {32'h0000_0000, busy_low};
    // function 0 and 15 always reported supported
    assign supp_all = support_bits_i | {6{16'h8001}};

    genvar g;
    generate
        for (g = 0; g < `SF_GROUPS; g++)
        begin : grp
            group_decide u_dec
            (
                .group_supported_i (group_supported_i[g]),
                .support_mask_i    (supp_all[g*16 +: 16]),
                .busy_mask_i       (busy_all[g*16 +: 16]),
                .current_i         (sel_r[g*4 +: 4]),
                .switch_mode_i     (mode_r),
                .arg_i             (arg_r[g*4 +: 4]),
                .status_o          (codes[g*4 +: 4]),
                .error_o           (errs[g]),
                .change_o          (chg[g])
            );
        end
    endgenerate

    // any group error cancels every switch
    wire        abort = |errs;
    wire [7:0]  ver   = version_one_i ? `SF_VER_1 : `SF_VER_0;
    // version 0 leaves busy fields undefined, drive them zero
    wire [95:0] busy_field = version_one_i ? busy_all : 96'h0;
    // support bits from the caller, selection codes, version, busy, zero tail
    wire [511:0] image = {16'h0000, supp_all, codes, ver, busy_field,
                          272'h0};

    wire [23:0] sel_next;
    generate
        for (g = 0; g < `SF_GROUPS; g++)
        begin : upd
            assign sel_next[g*4 +: 4] = (chg[g] && !abort) ? arg_r[g*4 +: 4]
                                                           : sel_r[g*4 +: 4];
        end
    endgenerate

    // sequencer: idle, build one cycle, shift 512 bits
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            switch_function_pkg::st_idle:
                if (cmd_valid_i)
                    state_nxt = switch_function_pkg::st_build;
            switch_function_pkg::st_build:
                state_nxt = switch_function_pkg::st_shift;
            switch_function_pkg::st_shift:
                if (rise && count_r == 9'h000)
                    state_nxt = switch_function_pkg::st_idle;
        endcase
    end

    assign cmd_ready_o = (state_r == switch_function_pkg::st_idle);

    // state and request capture
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            state_r <= switch_function_pkg::st_idle;
            mode_r  <= 1'b0;
            arg_r   <= 24'h000000;
        end
        else
        begin
            state_r <= state_nxt;
            if (cmd_valid_i && cmd_ready_o)
            begin
                mode_r <= switch_mode_i;
                arg_r  <= cmd_arg_i;
            end
        end
    end

    // selection: default speed after reset, updated only in switch mode
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            sel_r <= 24'h000000;
        else if (state_r == switch_function_pkg::st_build)
            sel_r <= sel_next;
    end

    // status shifter; data sent MSB first
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            shift_r      <= 512'h0;
            word_r       <= 512'h0;
            count_r      <= 9'h000;
            stat_bit_o   <= 1'b0;
            stat_valid_o <= 1'b0;
            stat_last_o  <= 1'b0;
        end
        else
        begin
            stat_valid_o <= 1'b0;
            stat_last_o  <= 1'b0;
            if (state_r == switch_function_pkg::st_build)
            begin
                shift_r <= image;
                word_r  <= image;
                count_r <= `SF_COUNT_TOP;
            end
            else if (state_r == switch_function_pkg::st_shift && rise)
            begin
                stat_bit_o   <= shift_r[`SF_SHIFT_MSB];
                stat_valid_o <= 1'b1;
                stat_last_o  <= (count_r == 9'h000);
                shift_r      <= {shift_r[510:0], 1'b0};
                count_r      <= count_r - 9'h001;
            end
        end
    end

    assign selection_o   = sel_r;
    assign status_word_o = word_r;
    // access mode group 1 function 1 selects high speed
    assign high_speed_o  = (sel_r[3:0] == `SF_FN_HIGH_SPEED);

    // assertions
    property p_ver_legal;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        stat_valid_o |-> (word_r[375:368] == `SF_VER_0 || word_r[375:368] == `SF_VER_1);
    endproperty
    a_ver_legal: assert property (p_ver_legal) else $error("bad version");

    property p_tail_zero;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        state_r == switch_function_pkg::st_shift |-> word_r[271:0] == 272'h0;
    endproperty
    a_tail_zero: assert property (p_tail_zero) else $error("tail not zero");

    property p_g2_mask;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        state_r == switch_function_pkg::st_shift |-> (word_r[303:288] & ~`SF_G2_MASK) == 16'h0;
    endproperty
    a_g2_mask: assert property (p_g2_mask) else $error("group 2 stray bit");

    property p_abort_keeps;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_r == switch_function_pkg::st_build && abort) |=> sel_r == $past(sel_r);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("switch not cancelled");

    property p_check_keeps;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_r == switch_function_pkg::st_build && !mode_r) |=> sel_r == $past(sel_r);
    endproperty
    a_check_keeps: assert property (p_check_keeps) else $error("check mode switched");

    property p_reset_default;
        @(posedge ref_clk_i)
        !reset_n_i |=> sel_r == 24'h000000 && !high_speed_o;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("not default speed");

    property p_codes_latched;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        state_r == switch_function_pkg::st_build |=> word_r[399:376] == $past(codes);
    endproperty
    a_codes_latched: assert property (p_codes_latched) else $error("codes lost");

    property p_busy_valid;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_r == switch_function_pkg::st_build && !version_one_i)
            |=> word_r[367:272] == 96'h0;
    endproperty
    a_busy_valid: assert property (p_busy_valid) else $error("busy with version 0");

    // group 1 view of the request; the other groups share the same decoder
    wire       at_build = (state_r == switch_function_pkg::st_build);
    wire [3:0] g1_arg   = arg_r[3:0];
    wire       g1_plain = group_supported_i[0] && g1_arg != `SF_CODE_DEFAULT
                          && g1_arg != `SF_CODE_KEEP;
    wire       g1_supp  = supp_all[g1_arg];
    wire       g1_busy  = access_busy_i[g1_arg];

    property p_g1_bsy;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && version_one_i |=> word_r[`SF_BUSY_LSB +: 16] == $past(access_busy_i);
    endproperty
    a_g1_bsy: assert property (p_g1_bsy) else $error("group 1 busy wrong");

    property p_upper_bsy;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build |=> word_r[`SF_VER_LSB - 1 : `SF_BUSY_G2_LSB + 16] == 64'h0;
    endproperty
    a_upper_bsy: assert property (p_upper_bsy) else $error("groups 3 to 6 busy");

    property p_g2_named;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && version_one_i |=>
            word_r[`SF_BUSY_G2_LSB + `SF_G2_VS_BIT] == $past(vendor_specific_busy_bit_i)
            && word_r[`SF_BUSY_G2_LSB + `SF_G2_SA_BIT] == $past(secure_application_busy_bit_i)
            && word_r[`SF_BUSY_G2_LSB + `SF_G2_MC_BIT] == $past(mobile_commerce_busy_bit_i);
    endproperty
    a_g2_named: assert property (p_g2_named) else $error("group 2 busy bit wrong");

    property p_ver_value;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build |=> word_r[`SF_VER_LSB +: 8] == ($past(version_one_i) ? `SF_VER_1 : `SF_VER_0);
    endproperty
    a_ver_value: assert property (p_ver_value) else $error("version mismatch");

    property p_g1_default;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && group_supported_i[0] && g1_arg == `SF_CODE_DEFAULT
            |=> word_r[`SF_SEL_LSB +: 4] == `SF_CODE_DEFAULT;
    endproperty
    a_g1_default: assert property (p_g1_default) else $error("default not 0");

    property p_g1_ready;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && g1_plain && g1_supp && !g1_busy
            |=> word_r[`SF_SEL_LSB +: 4] == $past(g1_arg);
    endproperty
    a_g1_ready: assert property (p_g1_ready) else $error("ready code wrong");

    property p_g1_held;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && g1_plain && g1_supp && g1_busy
            |=> word_r[`SF_SEL_LSB +: 4] == $past(sel_r[3:0])
            && sel_r[3:0] == $past(sel_r[3:0]);
    endproperty
    a_g1_held: assert property (p_g1_held) else $error("busy switched");

    property p_g1_unsup;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && g1_plain && !g1_supp |=> word_r[`SF_SEL_LSB +: 4] == `SF_CODE_KEEP;
    endproperty
    a_g1_unsup: assert property (p_g1_unsup) else $error("unsupported not Fh");

    property p_g1_keep;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && group_supported_i[0] && g1_arg == `SF_CODE_KEEP
            |=> word_r[`SF_SEL_LSB +: 4] == $past(sel_r[3:0])
            && sel_r[3:0] == $past(sel_r[3:0]);
    endproperty
    a_g1_keep: assert property (p_g1_keep) else $error("keep code moved selection");

    property p_g1_to_default;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && mode_r && !abort && group_supported_i[0] && g1_arg == `SF_CODE_DEFAULT
            |=> sel_r[3:0] == `SF_CODE_DEFAULT;
    endproperty
    a_g1_to_default: assert property (p_g1_to_default) else $error("no default switch");

    property p_g1_switched;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && mode_r && !abort && g1_plain && g1_supp && !g1_busy
            |=> sel_r[3:0] == $past(g1_arg);
    endproperty
    a_g1_switched: assert property (p_g1_switched) else $error("ready not selected");

    property p_g1_no_group;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        at_build && !group_supported_i[0]
            |=> word_r[`SF_SEL_LSB +: 4] == (($past(g1_arg) == `SF_CODE_DEFAULT
                || $past(g1_arg) == `SF_CODE_KEEP) ? `SF_CODE_DEFAULT : `SF_CODE_KEEP)
            && sel_r[3:0] == $past(sel_r[3:0]);
    endproperty
    a_g1_no_group: assert property (p_g1_no_group) else $error("bad group code");

    property p_speed_by_switch;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(high_speed_o) |-> $past(at_build && mode_r);
    endproperty
    a_speed_by_switch: assert property (p_speed_by_switch) else $error("speed unasked");

    property p_stream_order;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        stat_valid_o |-> stat_bit_o == word_r[9'(count_r + 9'h001)];
    endproperty
    a_stream_order: assert property (p_stream_order) else $error("bit out of order");
endmodule
